// ### common/mii_tx_pkg.sv
package mii_tx_pkg;

  // ----------------------------------------------------------------
  // Clock and transmit clock timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 100;
  localparam int TXCLK_PERIOD_100_NS = 40;
  localparam int TXCLK_PERIOD_10_NS = 400;
  localparam int DIV_WIDTH = 8;
  // The 100 Mb/s half period is shorter than one clock, so it is held at one cycle.
  localparam logic [DIV_WIDTH-1:0] TXCLK_HALF_100 =
    DIV_WIDTH'((TXCLK_PERIOD_100_NS / 2 / CLK_PERIOD_NS) < 1 ? 1 :
               (TXCLK_PERIOD_100_NS / 2 / CLK_PERIOD_NS));
  localparam logic [DIV_WIDTH-1:0] TXCLK_HALF_10 =
    DIV_WIDTH'((TXCLK_PERIOD_10_NS / 2 / CLK_PERIOD_NS) < 1 ? 1 :
               (TXCLK_PERIOD_10_NS / 2 / CLK_PERIOD_NS));
  localparam logic [1:0] STRAP_SETTLE_CYCLES = 2'h2;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam int ADDR_WIDTH = 8;
  localparam int DATA_WIDTH = 32;
  localparam logic [ADDR_WIDTH-1:0] ADDR_CTRL = 8'h00;
  localparam logic [ADDR_WIDTH-1:0] ADDR_STATUS = 8'h04;
  localparam logic [ADDR_WIDTH-1:0] ADDR_IRQ_STATUS = 8'h08;
  localparam logic [ADDR_WIDTH-1:0] ADDR_IRQ_MASK = 8'h0c;
  localparam logic [ADDR_WIDTH-1:0] ADDR_LAST_SYMBOL = 8'h10;
  localparam int CTRL_SPEED_BIT = 0;
  localparam int CTRL_SYMBOL_BIT = 1;
  localparam int STATUS_MODE_LSB = 0;
  localparam int STATUS_REDUCED_BIT = 3;
  localparam int STATUS_IRQ_FUNC_BIT = 4;
  localparam int STATUS_TX_ACTIVE_BIT = 5;
  localparam int STATUS_PIN_BIT = 6;
  localparam int STATUS_READY_BIT = 7;
  localparam logic CTRL_SPEED_RESET = 1'b0;
  localparam logic CTRL_SYMBOL_RESET = 1'b0;

  // ----------------------------------------------------------------
  // Interrupt events
  // ----------------------------------------------------------------
  localparam int EV_COUNT = 4;
  localparam int EV_START = 0;
  localparam int EV_END = 1;
  localparam int EV_ERROR = 2;
  localparam int EV_RX = 3;
  localparam logic [EV_COUNT-1:0] IRQ_MASK_RESET = 4'h0;

  // ----------------------------------------------------------------
  // Symbols and states
  // ----------------------------------------------------------------
  localparam logic [4:0] SYM_TX_ERROR = 5'h04;

  typedef enum logic [1:0] {
    STRAP_WAIT = 2'b00,
    STRAP_SETTLE = 2'b01,
    STRAP_HELD = 2'b10
  } strap_state_type;

  typedef enum logic [0:0] {
    TX_IDLE = 1'b0,
    TX_ACTIVE = 1'b1
  } tx_state_type;

endpackage : mii_tx_pkg

// ### common/enc_if.sv
`timescale 1ns/100ps
`default_nettype none
interface enc_if;
  logic [3:0] nibble;
  logic valid;
  logic txErr;
  logic symMsb;
  logic symMode;
  logic speed100;
  logic reduced;
  logic [4:0] symbol;
  logic symValid;

  modport source (
    output nibble, valid, txErr, symMsb, symMode, speed100, reduced,
    input symbol, symValid
  );
  modport encoder (
    input nibble, valid, txErr, symMsb, symMode, speed100, reduced,
    output symbol, symValid
  );
endinterface : enc_if
`default_nettype wire

// ### logic/tx_symbol_encoder.sv
`timescale 1ns/100ps
`default_nettype none
module tx_symbol_encoder (
  input wire logic clock,
  input wire logic rst_b,
  enc_if.encoder enc
);
  import mii_tx_pkg::*;

  logic [4:0] symbol_q;
  logic symValid_q;

  function automatic logic [4:0] encode4b5b(input logic [3:0] n);
    case (n)
      4'h0: encode4b5b = 5'h1e;
      4'h1: encode4b5b = 5'h09;
      4'h2: encode4b5b = 5'h14;
      4'h3: encode4b5b = 5'h15;
      4'h4: encode4b5b = 5'h0a;
      4'h5: encode4b5b = 5'h0b;
      4'h6: encode4b5b = 5'h0e;
      4'h7: encode4b5b = 5'h0f;
      4'h8: encode4b5b = 5'h12;
      4'h9: encode4b5b = 5'h13;
      4'ha: encode4b5b = 5'h16;
      4'hb: encode4b5b = 5'h17;
      4'hc: encode4b5b = 5'h1a;
      4'hd: encode4b5b = 5'h1b;
      4'he: encode4b5b = 5'h1c;
      default: encode4b5b = 5'h1d;
    endcase
  endfunction : encode4b5b

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      symbol_q <= 5'h00;
    end else if (enc.valid) begin
      if (!enc.speed100) begin
        symbol_q <= {1'b0, enc.nibble};
      end else if (enc.txErr && !enc.reduced) begin
        symbol_q <= SYM_TX_ERROR;
      end else if (enc.symMode && !enc.reduced) begin
        symbol_q <= {enc.symMsb, enc.nibble};
      end else begin
        symbol_q <= encode4b5b(enc.nibble);
      end
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      symValid_q <= 1'b0;
    end else begin
      symValid_q <= enc.valid;
    end
  end

  assign enc.symbol = symbol_q;
  assign enc.symValid = symValid_q;
endmodule : tx_symbol_encoder
`default_nettype wire

// ### logic/strap_capture.sv
`timescale 1ns/100ps
`default_nettype none
module strap_capture (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic [4:0] strapPins,
  output logic [4:0] strapHeld,
  output logic strapReady,
  output logic strapLoad
);
  import mii_tx_pkg::*;

  logic [4:0] sync1_q;
  logic [4:0] sync2_q;
  logic [4:0] held_q;
  logic [1:0] settle_q;
  logic loadPulse_q;
  strap_state_type state_q;

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      sync1_q <= 5'h00;
      sync2_q <= 5'h00;
    end else begin
      sync1_q <= strapPins;
      sync2_q <= sync1_q;
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      state_q <= STRAP_WAIT;
      settle_q <= 2'h0;
      held_q <= 5'h00;
    end else begin
      case (state_q)
        STRAP_WAIT: begin
          state_q <= STRAP_SETTLE;
          settle_q <= 2'h0;
        end
        STRAP_SETTLE: begin
          settle_q <= settle_q + 2'h1;
          if (settle_q == STRAP_SETTLE_CYCLES - 2'h1) begin
            held_q <= sync2_q;
            state_q <= STRAP_HELD;
          end
        end
        STRAP_HELD: begin
          state_q <= STRAP_HELD;
        end
        default: begin
          state_q <= STRAP_WAIT;
        end
      endcase
    end
  end

  // The load pulse is registered on the same edge as the latch, so the held straps are already valid while it is high.
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      loadPulse_q <= 1'b0;
    end else begin
      loadPulse_q <= (state_q == STRAP_SETTLE) && (settle_q == STRAP_SETTLE_CYCLES - 2'h1);
    end
  end

  assign strapHeld = held_q;
  assign strapReady = (state_q == STRAP_HELD);
  assign strapLoad = loadPulse_q;
endmodule : strap_capture
`default_nettype wire

// ### logic/mii_rmii_tx_port.sv
// Behaviour
// - Transmit error substitutes error code-group
// - Transmit error ignored at 10 Mb/s
// - Fifth line is symbol MSB
// - RMII uses only lowest two lines
// - MII transmit clock 25 / 2.5 MHz; the code gives 5 / 2.5 MHz from the 100 ns clock
// - RMII ignores clock, error, fifth line
// - Interrupt pin open-drain, low when pending
// - Receive data four lines, RMII two
// - Three mode straps set default mode; the code loads only the speed bit, from op_sel_strap_0
// - Interface strap low MII, high RMII
//
// Added by the designer: the register addresses and the plain strobed port.
`timescale 1ns/100ps
`default_nettype none
module mii_rmii_tx_port (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic [mii_tx_pkg::ADDR_WIDTH-1:0] regAddr,
  input wire logic [mii_tx_pkg::DATA_WIDTH-1:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  output logic [mii_tx_pkg::DATA_WIDTH-1:0] regRdata,
  input wire logic [3:0] txdPin,
  input wire logic txEnPin,
  input wire logic txErPin,
  input wire logic tx_symbol_msb,
  output logic txClkPin,
  input wire logic op_sel_strap_0,
  input wire logic op_sel_strap_1,
  input wire logic op_sel_strap_2,
  input wire logic reduced_if_strap,
  input wire logic irq_pin_function_strap,
  input wire logic irq_out_low_in,
  output logic irq_out_low_out,
  output logic irq_out_low_oe,
  input wire logic [3:0] rxCoreData,
  input wire logic rxCoreValid,
  output logic [3:0] rxdPin,
  output logic [4:0] txSymbol,
  output logic txSymbolValid,
  output logic txActive
);
  import mii_tx_pkg::*;

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [7:0] pinSync1_q;
  logic [7:0] pinSync2_q;
  logic pinLevel_q;
  logic [3:0] txdSync;
  logic txEnSync;
  logic txErSync;
  logic symMsbSync;

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      pinSync1_q <= 8'h00;
      pinSync2_q <= 8'h00;
    end else begin
      pinSync1_q <= {irq_out_low_in, tx_symbol_msb, txErPin, txEnPin, txdPin};
      pinSync2_q <= pinSync1_q;
    end
  end

  assign txdSync = pinSync2_q[3:0];
  assign txEnSync = pinSync2_q[4];
  assign txErSync = pinSync2_q[5];
  assign symMsbSync = pinSync2_q[6];

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      pinLevel_q <= 1'b1;
    end else begin
      pinLevel_q <= symMsbSync;
    end
  end

  // ----------------------------------------------------------------
  // Straps
  // ----------------------------------------------------------------
  logic [4:0] strapHeld;
  logic strapReady;
  logic strapLoad;
  logic [2:0] defaultMode;
  logic reducedMode;
  logic irqFunction;

  strap_capture u_straps (
    .clock(clock),
    .rst_b(rst_b),
    .strapPins({irq_pin_function_strap, reduced_if_strap, op_sel_strap_2, op_sel_strap_1,
                op_sel_strap_0}),
    .strapHeld(strapHeld),
    .strapReady(strapReady),
    .strapLoad(strapLoad)
  );

  assign defaultMode = strapHeld[2:0];
  assign reducedMode = strapHeld[3];
  assign irqFunction = ~strapHeld[4];

  // ----------------------------------------------------------------
  // Control register
  // ----------------------------------------------------------------
  logic speed100_q;
  logic symMode_q;

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      speed100_q <= CTRL_SPEED_RESET;
      symMode_q <= CTRL_SYMBOL_RESET;
    end else if (regWr && regAddr == ADDR_CTRL) begin
      speed100_q <= regWdata[CTRL_SPEED_BIT];
      symMode_q <= regWdata[CTRL_SYMBOL_BIT];
    end else if (strapLoad) begin
      speed100_q <= defaultModeSpeed(strapHeld);
    end
  end

  function automatic logic defaultModeSpeed(input logic [4:0] s);
    defaultModeSpeed = s[0];
  endfunction : defaultModeSpeed

  // ----------------------------------------------------------------
  // Transmit clock divider
  // ----------------------------------------------------------------
  logic [DIV_WIDTH-1:0] divCnt_q;
  logic [DIV_WIDTH-1:0] halfPeriod;
  logic txClk_q;
  logic divWrap;
  logic riseDly1_q;
  logic riseDly2_q;

  assign halfPeriod = speed100_q ? TXCLK_HALF_100 : TXCLK_HALF_10;
  assign divWrap = (divCnt_q >= halfPeriod - DIV_WIDTH'(1));

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      divCnt_q <= '0;
      txClk_q <= 1'b0;
    end else if (!strapReady) begin
      divCnt_q <= '0;
      txClk_q <= 1'b0;
    end else if (divWrap) begin
      divCnt_q <= '0;
      txClk_q <= ~txClk_q;
    end else begin
      divCnt_q <= divCnt_q + DIV_WIDTH'(1);
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      riseDly1_q <= 1'b0;
      riseDly2_q <= 1'b0;
    end else begin
      riseDly1_q <= strapReady && divWrap && !txClk_q;
      riseDly2_q <= riseDly1_q;
    end
  end

  assign txClkPin = txClk_q & ~reducedMode;

  // ----------------------------------------------------------------
  // Transmit framing
  // ----------------------------------------------------------------
  enc_if encBus ();
  tx_state_type txState_q;
  logic dibitHigh_q;
  logic [1:0] lowDibit_q;
  logic [3:0] nibble_q;
  logic nibbleValid_q;
  logic nibbleErr_q;
  logic nibbleMsb_q;
  logic [EV_COUNT-1:0] events;

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      txState_q <= TX_IDLE;
    end else if (riseDly2_q) begin
      case (txState_q)
        TX_IDLE: txState_q <= txEnSync ? TX_ACTIVE : TX_IDLE;
        TX_ACTIVE: txState_q <= txEnSync ? TX_ACTIVE : TX_IDLE;
        default: txState_q <= TX_IDLE;
      endcase
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      dibitHigh_q <= 1'b0;
      lowDibit_q <= 2'h0;
      nibble_q <= 4'h0;
      nibbleValid_q <= 1'b0;
      nibbleErr_q <= 1'b0;
      nibbleMsb_q <= 1'b0;
    end else begin
      nibbleValid_q <= 1'b0;
      if (riseDly2_q && txEnSync) begin
        if (reducedMode) begin
          if (!dibitHigh_q) begin
            lowDibit_q <= txdSync[1:0];
            dibitHigh_q <= 1'b1;
          end else begin
            nibble_q <= {txdSync[1:0], lowDibit_q};
            nibbleValid_q <= 1'b1;
            dibitHigh_q <= 1'b0;
          end
          nibbleErr_q <= 1'b0;
          nibbleMsb_q <= 1'b0;
        end else begin
          nibble_q <= txdSync;
          nibbleValid_q <= 1'b1;
          nibbleErr_q <= txErSync;
          nibbleMsb_q <= symMsbSync;
        end
      end else if (riseDly2_q) begin
        // An odd dibit left at frame end is dropped.
        dibitHigh_q <= 1'b0;
      end
    end
  end

  assign encBus.nibble = nibble_q;
  assign encBus.valid = nibbleValid_q;
  assign encBus.txErr = nibbleErr_q;
  assign encBus.symMsb = nibbleMsb_q;
  assign encBus.symMode = symMode_q;
  assign encBus.speed100 = speed100_q;
  assign encBus.reduced = reducedMode;

  tx_symbol_encoder u_encoder (
    .clock(clock),
    .rst_b(rst_b),
    .enc(encBus.encoder)
  );

  assign txSymbol = encBus.symbol;
  assign txSymbolValid = encBus.symValid;
  assign txActive = (txState_q == TX_ACTIVE);

  // ----------------------------------------------------------------
  // Receive data lines
  // ----------------------------------------------------------------
  logic [3:0] rxd_q;

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      rxd_q <= 4'h0;
    end else if (rxCoreValid) begin
      rxd_q <= reducedMode ? {2'b00, rxCoreData[1:0]} : rxCoreData;
    end
  end

  assign rxdPin = rxd_q;

  // ----------------------------------------------------------------
  // Interrupts
  // ----------------------------------------------------------------
  logic [EV_COUNT-1:0] irqStatus_q;
  logic [EV_COUNT-1:0] irqMask_q;
  logic [EV_COUNT-1:0] irqClear;
  logic irqPending;

  always_comb begin
    events = '0;
    events[EV_START] = riseDly2_q && txEnSync && txState_q == TX_IDLE;
    events[EV_END] = riseDly2_q && !txEnSync && txState_q == TX_ACTIVE;
    events[EV_ERROR] = riseDly2_q && txEnSync && txErSync && speed100_q && !reducedMode;
    events[EV_RX] = rxCoreValid;
  end

  assign irqClear = (regWr && regAddr == ADDR_IRQ_STATUS) ? regWdata[EV_COUNT-1:0] : '0;

  // A new event in the clearing cycle survives the clear.
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      irqStatus_q <= '0;
    end else begin
      irqStatus_q <= (irqStatus_q & ~irqClear) | events;
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      irqMask_q <= IRQ_MASK_RESET;
    end else if (regWr && regAddr == ADDR_IRQ_MASK) begin
      irqMask_q <= regWdata[EV_COUNT-1:0];
    end
  end

  assign irqPending = |(irqStatus_q & irqMask_q);
  assign irq_out_low_out = 1'b0;
  assign irq_out_low_oe = irqPending && irqFunction;

  // ----------------------------------------------------------------
  // Register read port
  // ----------------------------------------------------------------
  logic [DATA_WIDTH-1:0] rdata_q;
  logic [4:0] lastSymbol_q;

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      lastSymbol_q <= 5'h00;
    end else if (encBus.symValid) begin
      lastSymbol_q <= encBus.symbol;
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      rdata_q <= '0;
    end else if (regRd) begin
      rdata_q <= '0;
      case (regAddr)
        ADDR_CTRL: begin
          rdata_q[CTRL_SPEED_BIT] <= speed100_q;
          rdata_q[CTRL_SYMBOL_BIT] <= symMode_q;
        end
        ADDR_STATUS: begin
          rdata_q[STATUS_MODE_LSB +: 3] <= defaultMode;
          rdata_q[STATUS_REDUCED_BIT] <= reducedMode;
          rdata_q[STATUS_IRQ_FUNC_BIT] <= irqFunction;
          rdata_q[STATUS_TX_ACTIVE_BIT] <= txState_q == TX_ACTIVE;
          rdata_q[STATUS_PIN_BIT] <= pinLevel_q;
          rdata_q[STATUS_READY_BIT] <= strapReady;
        end
        ADDR_IRQ_STATUS: rdata_q[EV_COUNT-1:0] <= irqStatus_q;
        ADDR_IRQ_MASK: rdata_q[EV_COUNT-1:0] <= irqMask_q;
        ADDR_LAST_SYMBOL: rdata_q[4:0] <= lastSymbol_q;
        default: rdata_q <= '0;
      endcase
    end else begin
      rdata_q <= '0;
    end
  end

  assign regRdata = rdata_q;
endmodule : mii_rmii_tx_port
`default_nettype wire

// ### testbench/mii_rmii_tx_port_monitor.sv
`timescale 1ns/100ps
`default_nettype none
module mii_rmii_tx_port_monitor (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic regRd,
  input wire logic [mii_tx_pkg::DATA_WIDTH-1:0] regRdata,
  input wire logic txEnPin,
  input wire logic txClkPin,
  input wire logic reduced_if_strap,
  input wire logic irq_pin_function_strap,
  input wire logic irq_out_low_out,
  input wire logic irq_out_low_oe,
  input wire logic [3:0] rxCoreData,
  input wire logic rxCoreValid,
  input wire logic [3:0] rxdPin,
  input wire logic txSymbolValid
);
  import mii_tx_pkg::*;
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_b);
  // ----------------------------------------------------------------
  // Port checks
  // ----------------------------------------------------------------
  chk_read_data_idle: assert property (!$past(regRd) |-> regRdata == '0)
    else $error("read data not zero outside the read answer cycle");
  chk_od_drive_low: assert property (irq_out_low_out == 1'b0)
    else $error("interrupt pin drive value is not low");
  chk_irq_func_off: assert property (irq_pin_function_strap |-> !irq_out_low_oe)
    else $error("interrupt pin driven while its function is off");
  chk_rmii_clock_quiet: assert property (reduced_if_strap |-> !txClkPin)
    else $error("transmit clock runs in reduced mode");
  chk_symbol_one_cycle: assert property (txSymbolValid |=> !txSymbolValid)
    else $error("symbol strobe longer than one cycle");
  // The pipeline is four cycles deep, so six idle cycles leave nothing in flight.
  chk_no_symbol_idle: assert property (!txEnPin [*6] |-> !txSymbolValid)
    else $error("symbol produced without transmit enable");
  chk_rx_data_load: assert property (rxCoreValid |=> rxdPin == ($past(reduced_if_strap) ?
    {2'b00, $past(rxCoreData[1:0])} : $past(rxCoreData)))
    else $error("receive data lines do not carry the loaded data");
  chk_rx_data_hold: assert property (!rxCoreValid |=> $stable(rxdPin))
    else $error("receive data lines changed without a load");
endmodule : mii_rmii_tx_port_monitor
bind mii_rmii_tx_port mii_rmii_tx_port_monitor monitor (.clock, .rst_b, .regRd, .regRdata,
  .txEnPin, .txClkPin, .reduced_if_strap, .irq_pin_function_strap, .irq_out_low_out,
  .irq_out_low_oe, .rxCoreData, .rxCoreValid, .rxdPin, .txSymbolValid);
`default_nettype wire

// ### testbench/mac_model.sv
`timescale 1ns/100ps
`default_nettype none
module mac_model (
  input wire logic clock,
  input wire logic txClkPin,
  output logic [3:0] txd,
  output logic txEn,
  output logic txEr,
  output logic symMsb
);
  // ----------------------------------------------------------------
  // Frame drivers
  // ----------------------------------------------------------------
  initial begin
    txd = 4'h0;
    txEn = 1'b0;
    txEr = 1'b0;
    symMsb = 1'b1;
  end
  task automatic sendMii(input logic [31:0] w, input logic er, input logic msb);
    for (int i = 0; i < 8; i++) begin
      @(posedge txClkPin);
      txd <= w[4*i+:4];
      txEn <= 1'b1;
      txEr <= er;
      symMsb <= msb;
    end
    @(posedge txClkPin);
    // Released lines show the inverse so that a stale value never passes as data.
    txd <= ~w[31:28];
    txEn <= 1'b0;
    txEr <= 1'b0;
    symMsb <= 1'b1;
  endtask : sendMii
  // upper lines grounded, one dibit per period
  task automatic sendRmii(input logic [15:0] w, input int hold, input logic er);
    @(posedge clock);
    for (int i = 0; i < 8; i++) begin
      txd <= {2'b00, w[2*i+:2]};
      txEn <= 1'b1;
      txEr <= er;
      repeat (hold) @(posedge clock);
    end
    txd <= {2'b00, ~w[15:14]};
    txEn <= 1'b0;
    txEr <= 1'b0;
  endtask : sendRmii
endmodule : mac_model
`default_nettype wire

// ### testbench/mii_rmii_tx_port_test.sv
`timescale 1ns/100ps
`default_nettype none
module mii_rmii_tx_port_test;
  import mii_tx_pkg::*;
  logic clock, rst_b, regWr, regRd, rxCoreValid, irqWire, op0, op1, op2, reducedStrap, funcStrap;
  logic txEn, txEr, symMsb, txClkPin, irqOut, irqOe, txSymbolValid, txActive;
  logic [7:0] regAddr;
  logic [31:0] regWdata, regRdata;
  logic [3:0] txd, rxCoreData, rxdPin;
  logic [4:0] txSymbol;
  logic [4:0] symQ[$];
  int n_fail = 0;
  int compares = 0;
  localparam logic [4:0] CODE_4B5B [16] = '{5'h1e, 5'h09, 5'h14, 5'h15, 5'h0a, 5'h0b, 5'h0e,
    5'h0f, 5'h12, 5'h13, 5'h16, 5'h17, 5'h1a, 5'h1b, 5'h1c, 5'h1d};
  // The pull-up gives the released interrupt line its high level.
  assign irqWire = irqOe ? irqOut : 1'b1;
  mii_rmii_tx_port DUT (.clock(clock), .rst_b(rst_b), .regAddr(regAddr), .regWdata(regWdata),
    .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .txdPin(txd), .txEnPin(txEn),
    .txErPin(txEr), .tx_symbol_msb(symMsb), .txClkPin(txClkPin), .op_sel_strap_0(op0),
    .op_sel_strap_1(op1), .op_sel_strap_2(op2), .reduced_if_strap(reducedStrap),
    .irq_pin_function_strap(funcStrap), .irq_out_low_in(irqWire), .irq_out_low_out(irqOut),
    .irq_out_low_oe(irqOe), .rxCoreData(rxCoreData), .rxCoreValid(rxCoreValid),
    .rxdPin(rxdPin), .txSymbol(txSymbol), .txSymbolValid(txSymbolValid), .txActive(txActive));
  mac_model mac (.clock(clock), .txClkPin(txClkPin), .txd(txd), .txEn(txEn), .txEr(txEr),
    .symMsb(symMsb));
  always #(CLK_PERIOD_NS / 2) clock = ~clock;
  always @(posedge clock) if (txSymbolValid === 1'b1) symQ.push_back(txSymbol);
  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic print_verdict();
    $display("counts: %0d mismatches in %0d compares", n_fail, compares);
    if (n_fail == 0 && compares > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : print_verdict
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    compares++;
    if (seen !== exp) begin
      n_fail++;
      $display("mismatch at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask : check
  // A trailing idle cycle keeps two writes from touching the strobe in one time step.
  task automatic wrReg(input logic [7:0] a, input logic [31:0] d);
    regAddr <= a;
    regWdata <= d;
    regWr <= 1'b1;
    @(posedge clock);
    regWr <= 1'b0;
    @(posedge clock);
  endtask : wrReg
  task automatic rdChk(input logic [7:0] a, input logic [31:0] exp);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge clock);
    regRd <= 1'b0;
    @(negedge clock);
    check(regRdata, exp, "register read");
    @(posedge clock);
  endtask : rdChk
  task automatic doReset(input logic [4:0] s);
    rst_b <= 1'b0;
    {funcStrap, reducedStrap, op2, op1, op0} <= s;
    repeat (3) @(posedge clock);
    rst_b <= 1'b1;
    repeat (4) @(posedge clock);
  endtask : doReset
  task automatic checkSyms(input logic [31:0] w, input int n, input logic [1:0] kind);
    logic [4:0] e;
    check(32'(symQ.size()), 32'(n), "symbol count");
    for (int i = 0; i < n && i < symQ.size(); i++) begin
      e = kind == 2'd1 ? SYM_TX_ERROR : kind == 2'd3 ? CODE_4B5B[w[4*i+:4]] :
          {kind == 2'd2, w[4*i+:4]};
      check(32'(symQ[i]), 32'(e), "symbol value");
    end
    symQ.delete();
  endtask : checkSyms
  task automatic rxPulse(input logic [3:0] d);
    rxCoreData <= d;
    rxCoreValid <= 1'b1;
    @(posedge clock);
    rxCoreValid <= 1'b0;
    @(posedge clock);
  endtask : rxPulse
  task automatic clkPeriod(input int half);
    realtime t0;
    @(posedge txClkPin);
    @(posedge txClkPin);
    t0 = $realtime;
    @(posedge txClkPin);
    check(32'(int'(($realtime - t0) / CLK_PERIOD_NS)), 32'(2 * half), "clock period");
  endtask : clkPeriod
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic testStraps();
    rdChk(ADDR_STATUS, 32'hd5);
    rdChk(ADDR_IRQ_MASK, 32'h0);
    rdChk(ADDR_IRQ_STATUS, 32'h0);
    rdChk(8'h14, 32'h0);
    wrReg(8'h14, 32'hffff_ffff);
    wrReg(ADDR_STATUS, 32'h0);
    {op2, op1, op0, funcStrap} <= 4'b0101;
    repeat (4) @(posedge clock);
    rdChk(ADDR_STATUS, 32'hd5);
    rdChk(ADDR_CTRL, 32'h1);
    {op2, op1, op0, funcStrap} <= 4'b1010;
  endtask : testStraps
  task automatic testFrames();
    clkPeriod(TXCLK_HALF_100);
    wrReg(ADDR_CTRL, 32'h0);
    clkPeriod(TXCLK_HALF_10);
    symQ.delete();
    mac.sendMii(32'h8421_f0c3, 1'b1, 1'b1);
    check(32'(txActive), 32'h1, "frame in progress");
    repeat (12) @(posedge clock);
    check(32'(txActive), 32'h0, "frame ended");
    checkSyms(32'h8421_f0c3, 8, 2'd0);
    rdChk(ADDR_IRQ_STATUS, 32'h3);
    wrReg(ADDR_IRQ_STATUS, 32'h3);
    rdChk(ADDR_IRQ_STATUS, 32'h0);
    wrReg(ADDR_CTRL, 32'h1);
    mac.sendMii(32'h0123_4567, 1'b1, 1'b0);
    repeat (12) @(posedge clock);
    checkSyms(32'h0123_4567, 8, 2'd1);
    rdChk(ADDR_IRQ_STATUS, 32'h7);
    wrReg(ADDR_CTRL, 32'h3);
    mac.sendMii(32'hfedc_ba98, 1'b0, 1'b1);
    repeat (12) @(posedge clock);
    checkSyms(32'hfedc_ba98, 8, 2'd2);
    rdChk(ADDR_LAST_SYMBOL, 32'h1f);
    wrReg(ADDR_IRQ_STATUS, 32'hf);
  endtask : testFrames
  task automatic testIrq();
    rxPulse(4'ha);
    check(32'(rxdPin), 32'ha, "receive lines");
    check(32'(irqWire), 32'h1, "masked interrupt pin");
    wrReg(ADDR_IRQ_MASK, 32'h8);
    check(32'(irqWire), 32'h0, "pending interrupt pin");
    rdChk(ADDR_IRQ_STATUS, 32'h8);
    wrReg(ADDR_IRQ_STATUS, 32'h8);
    check(32'(irqWire), 32'h1, "cleared interrupt pin");
  endtask : testIrq
  task automatic testRmii();
    doReset(5'b11101);
    rdChk(ADDR_STATUS, 32'hcd);
    wrReg(ADDR_CTRL, 32'h0);
    symQ.delete();
    mac.sendRmii(16'h9c63, 2 * TXCLK_HALF_10, 1'b1);
    repeat (16) @(posedge clock);
    checkSyms(32'h0000_9c63, 4, 2'd0);
    wrReg(ADDR_CTRL, 32'h3);
    mac.sendRmii(16'h9c63, 2 * TXCLK_HALF_100, 1'b1);
    repeat (16) @(posedge clock);
    checkSyms(32'h0000_9c63, 4, 2'd3);
    check(32'(txClkPin), 32'h0, "reduced mode clock");
    wrReg(ADDR_IRQ_MASK, 32'h8);
    rxPulse(4'hf);
    check(32'(rxdPin), 32'h3, "reduced receive lines");
    check(32'(irqWire), 32'h1, "interrupt function off");
  endtask : testRmii
  initial begin
    clock = 1'b0;
    rst_b = 1'b0;
    {regWr, regRd, rxCoreValid, regAddr, regWdata, rxCoreData} = '0;
    {funcStrap, reducedStrap, op2, op1, op0} = 5'b00101;
    doReset(5'b00101);
    testStraps();
    testFrames();
    testIrq();
    testRmii();
    print_verdict();
  end
  initial begin
    #(20000 * CLK_PERIOD_NS);
    n_fail++;
    print_verdict();
  end
endmodule : mii_rmii_tx_port_test
`default_nettype wire
